// *** common/eps_cfg.svh ***
`ifndef EPS_CFG_SVH
`define EPS_CFG_SVH

// ==========================================================================
// Register byte offsets on the AHB-Lite slave.
// ==========================================================================
`define EPS_OFF_CTRL 8'h00
`define EPS_OFF_STEPS 8'h04
`define EPS_OFF_TOTAL 8'h08
`define EPS_OFF_SOL_MAX 8'h0c
`define EPS_OFF_VEL_UNIT 8'h10
`define EPS_OFF_TELEGRAM 8'h14
`define EPS_OFF_STATUS 8'h18
`define EPS_OFF_SUPPORT 8'h1c
`define EPS_OFF_REVS 8'h20
`define EPS_OFF_ZONE 8'h24
`define EPS_OFF_POS 8'h28
`define EPS_OFF_VEL 8'h2c

// ==========================================================================
// Field positions.
// ==========================================================================
`define EPS_CTRL_CLASS4 0
`define EPS_CTRL_SCALE 1
`define EPS_CTRL_COMPAT_OFF 2
`define EPS_CTRL_W 3
`define EPS_FLT_MEM 0
`define EPS_FLT_SOL 1
`define EPS_FLT_PARAM 2
`define EPS_ST_WARN_LSB 8
`define EPS_ST_RED 16
`define EPS_ST_ACT 17
`define EPS_ST_BUSY 18

// ==========================================================================
// Reset values, limits and encodings.
// ==========================================================================
`define EPS_RST_CTRL 3'h0
`define EPS_RST_SOL_MAX 8'h01
`define EPS_RST_VEL_UNIT 2'h0
`define EPS_RST_TELEGRAM 8'h51
`define EPS_TG_NO_VEL 8'h51
`define EPS_FLT_SUPPORTED 32'h0000_0007
`define EPS_STEPS_MIN 32'h0000_0001
`define EPS_TOTAL_MIN 32'h0000_0002
`define EPS_SOL_MIN 8'h01
`define EPS_SOL_NONCOMPAT 8'h01
`define EPS_SOL_SAT 8'hff
`define EPS_VU_SPS 2'h0
`define EPS_VU_S100MS 2'h1
`define EPS_VU_S10MS 2'h2
`define EPS_VU_RPM 2'h3
`define EPS_VEL_MUL_SPS 32'h0000_000a
`define EPS_VEL_DIV_10MS 32'h0000_000a
`define EPS_VEL_MUL_RPM 32'h0000_0258

// ==========================================================================
// Timing and hardware resolution defaults.
// ==========================================================================
`define EPS_CLK_HZ 40000000
`define EPS_VEL_PERIOD_MS 100
`define EPS_MS_PER_S 1000
`define EPS_HW_ST_BITS 16
`define EPS_HW_MT_BITS 14
`define EPS_DIV_W 48

`endif

// *** common/eps_pkg.sv ***
package eps_pkg;

    // ======================================================================
    // Sequencer states, Gray coded along IDLE-REV-ZONE-POS-VEL.
    // ======================================================================
    typedef enum logic [2:0] {
        EPS_S_IDLE = 3'h0,
        EPS_S_REV = 3'h1,
        EPS_S_ZONE = 3'h3,
        EPS_S_POS = 3'h2,
        EPS_S_VEL = 3'h6
    } eps_state_t;

    // Bus slave state: pending phases, latched address and read data.
    typedef struct packed {
        logic hready;
        logic rd_pend;
        logic wr_pend;
        logic [7:0] addr;
        logic [31:0] hrdata;
    } eps_bus_t;

    // Software settings.
    typedef struct packed {
        logic [2:0] ctrl;
        logic [31:0] steps;
        logic [31:0] total;
        logic [7:0] sol_max;
        logic [1:0] vel_unit;
        logic [7:0] telegram;
    } eps_cfg_t;

    // Computation and diagnostic state.
    typedef struct packed {
        eps_state_t st;
        logic run;
        logic dirty;
        logic vel_pend;
        logic [31:0] tick;
        logic [31:0] revs;
        logic [31:0] zone;
        logic [31:0] pos;
        logic signed [31:0] delta;
        logic signed [31:0] prev;
        logic signed [31:0] vel;
        logic red;
        logic [2:0] faults;
        logic fault;
        logic [7:0] sol_cnt;
        logic alarm;
    } eps_core_t;

    // Whole state of the top module.
    typedef struct packed {
        eps_bus_t bus;
        eps_cfg_t cfg;
        eps_core_t core;
    } eps_top_st_t;

endpackage : eps_pkg

// *** dv/eps_ctl_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Controller side: AHB-Lite master, single word transfers.
module eps_ctl_model (
    // Clock and answer.
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    // Request.
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [31:0] o_hwdata
);
    // Bus idles at time zero.
    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hwdata = 32'h0;
    end

    // Enter just after an edge; waits end only by the bench watchdog.
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        o_hsel <= 1'b1;
        o_htrans <= 2'h2;
        o_hwrite <= w;
        o_haddr <= a;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        q = i_hrdata;
    endtask : xfer
endmodule : eps_ctl_model

// *** dv/eps_top_bench.sv ***
`timescale 1ns/1ps
// ==========================================
// Bench: register table, scaling, zone wrap, faults.
module eps_top_bench;
    logic clk, rst_n, hsel, hwrite, rdy, mem_f, red, flt, hresp, sfail, sok, alm;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q, pos, vel;
    logic [29:0] raw;
    int mismatches, total_checks;
    // Rows: address, write (bit 32 set) and expected read back.
    logic [31:0] ra[8] = '{8'h14, 8'h0c, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c, 8'h30};
    logic [32:0] rw[8] = '{0, 0, 33'h1_0000_0000, 33'h1_0000_0001, 33'h1_0000_00ff,
                           33'h1_0000_0003, 33'h1_0000_0000, 33'h1_0000_0005};
    logic [31:0] rx[8] = '{8'h51, 1, 32'h1_0000, 32'h4000_0000, 8'hff, 3, 7, 0};

    eps_ctl_model i_ctl (.i_clk(clk), .i_hready(rdy), .i_hrdata(hrdata), .o_hsel(hsel),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hwdata(hwdata));
    eps_top #(.VEL_TICKS(200)) i_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(rdy), .O_HRDATA(hrdata), .O_HREADYOUT(rdy),
        .O_HRESP(hresp), .I_RAW_POS(raw), .I_MEM_FAULT(mem_f), .I_SOL_FAIL(sfail),
        .I_SOL_OK(sok), .O_POS(pos), .O_VEL(vel), .O_RED_ZONE(red), .O_FAULT(flt),
        .O_ALARM(alm));

    task chk(input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk

    task wr(input logic [31:0] a, d);
        i_ctl.xfer(1'b1, a, d, q);
    endtask : wr

    task rd(input logic [31:0] a);
        i_ctl.xfer(1'b0, a, 32'h0, q);
    endtask : rd

    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test

    // Clock at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard, far beyond the expected run.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test;
    end

    initial begin
        rst_n = 1'b0;
        raw = 30'h1_2345;
        mem_f = 1'b0;
        sfail = 1'b0;
        sok = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            if (rw[i][32]) wr(ra[i], rw[i][31:0]);
            rd(ra[i]);
            chk(q, rx[i]);
        end
        rd(8'h18);
        chk({q[15:8], 7'h0, q[2], flt}, 32'h3);
        wr(8'h18, 32'h7);
        rd(8'h18);
        chk(q[2:0], 0);
        // Two ranges of 6748 revolutions and part of one fit the full travel: a zone exists.
        wr(8'h08, 32'h1a5c_0000);
        // No preset input here: the controller waits out the recompute instead.
        wr(8'h00, 32'h3);
        repeat (400) @(posedge clk);
        rd(8'h20);
        chk(q, 32'h1a5c);
        rd(8'h24);
        chk(q, 32'h0b48_0000);
        chk(pos, 32'h1_2345);
        raw <= 30'h3fff_ffff;
        repeat (400) @(posedge clk);
        chk({red, pos[30:0]}, 32'h8b47_ffff);
        raw <= 30'h0;
        repeat (400) @(posedge clk);
        chk({red, pos[30:0]}, 0);
        chk(vel, 0);
        wr(8'h00, 32'h1);
        raw <= 30'h3fff_ffff;
        repeat (400) @(posedge clk);
        chk(pos, 32'h3fff_ffff);
        // Two failures tolerated in compatibility mode, then only one without it.
        wr(8'h0c, 32'h2);
        sfail <= 1'b1;
        repeat (2) @(posedge clk);
        chk(flt, 0);
        repeat (3) @(posedge clk);
        chk({flt, alm}, 2'h3);
        sfail <= 1'b0;
        sok <= 1'b1;
        wr(8'h00, 32'h5);
        sok <= 1'b0;
        wr(8'h18, 32'h7);
        sfail <= 1'b1;
        repeat (4) @(posedge clk);
        chk(flt, 1);
        sfail <= 1'b0;
        mem_f <= 1'b1;
        repeat (3) @(posedge clk);
        chk(flt, 1);
        rd(8'h18);
        chk(q[2:0], 3'h3);
        // Reset in mid-run: outputs fall back and settings return to defaults.
        rst_n <= 1'b0;
        mem_f <= 1'b0;
        @(posedge clk);
        chk({rdy, hresp, flt, red, alm}, 5'h10);
        chk(pos | vel, 0);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h04);
        chk(q, 32'h1_0000);
        end_of_test;
    end
endmodule : eps_top_bench

// *** hw/eps_div.sv ***
`timescale 1ns/1ps
`include "eps_cfg.svh"

// Restoring divider, one quotient bit per clock; W+1 cycles from start to done.
module eps_div #(
    parameter int W = `EPS_DIV_W
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Request.
    input wire logic i_start,
    input wire logic [W-1:0] i_num,
    input wire logic [W-1:0] i_den,
    // Answer.
    output logic o_busy,
    output logic o_done,
    output logic [W-1:0] o_quo,
    output logic [W-1:0] o_rem
);
    localparam int CW = $clog2(W + 1);

    // Local state record; widths follow the parameter.
    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] cnt;
        logic [W-1:0] rem;
        logic [W-1:0] quo;
        logic [W-1:0] den;
    } eps_div_st_t;

    eps_div_st_t q;
    eps_div_st_t d;
    logic [W-1:0] trial;

    // ======================================================================
    // Next state: shift one numerator bit into the remainder per cycle.
    // ======================================================================
    always_comb begin
        d = q;
        d.done = 1'b0;
        trial = {q.rem[W-2:0], q.quo[W-1]};
        if (!q.busy && i_start) begin
            // A start while busy is ignored, so operands stay stable.
            d.busy = 1'b1;
            d.cnt = CW'(W);
            d.quo = i_num;
            d.rem = '0;
            d.den = i_den;
        end else if (q.busy) begin
            if (trial >= q.den) begin
                d.rem = trial - q.den;
                d.quo = {q.quo[W-2:0], 1'b1};
            end else begin
                d.rem = trial;
                d.quo = {q.quo[W-2:0], 1'b0};
            end
            d.cnt = q.cnt - CW'(1);
            if (q.cnt == CW'(1)) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end
    end

    // Register the state.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_busy = q.busy;
    assign o_done = q.done;
    assign o_quo = q.quo;
    assign o_rem = q.rem;

    // The answer must hold the division identity when it is flagged.
    div_ident_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_done |-> (o_quo * q.den + o_rem == $past(i_num, W + 1)) || q.den == '0)
        else $error("divider result does not match its operands");

endmodule : eps_div

// *** hw/eps_top.sv ***
`timescale 1ns/1ps
`include "eps_cfg.svh"

// How it works
// [R1] Scaling only with class-4 and scaling enabled.
// [R2] Steps per revolution accepted from 1 to cpr.
// [R3] Total range accepted from 2 to full resolution.
// [R4] Revolutions equal total range over steps.
// [R5] Controller should pick power-of-two revolution counts.
// [R6] Excess zone is remainder of repeated subtraction.
// [R7] Past the excess zone the position returns zero.
// [R8] Controller must preset again after scaling changes.
// [R9] Sign-of-life tolerance 1..255, only in compatibility.
// [R10] Velocity units: 0 s, 1 100ms, 2 10ms, 3 rpm.
// [R11] Telegram 81 ignores units; 82 to 84 use them.
// [R12] Velocity recomputed once every 100 ms.
// [R13] Fault set when position could be wrong.
// [R14] Warnings never raised, only faults.
// [R15] Alarms pushed out; diagnostics only on request.
// [R16] Status record shows faults, warnings and support.
// [R17] Scaling enable 1 on, 0 uses hardware resolution.
// [R18] Scaled position is raw times steps over cpr, wrapped.
module eps_top #(
    parameter int HW_ST_BITS = `EPS_HW_ST_BITS,
    parameter int HW_MT_BITS = `EPS_HW_MT_BITS,
    parameter int VEL_TICKS = `EPS_CLK_HZ / `EPS_MS_PER_S * `EPS_VEL_PERIOD_MS
) (
    // Clock and reset.
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // AHB-Lite slave.
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // Encoder sensing and master supervision.
    input wire logic [HW_ST_BITS+HW_MT_BITS-1:0] I_RAW_POS,
    input wire logic I_MEM_FAULT,
    input wire logic I_SOL_FAIL,
    input wire logic I_SOL_OK,
    // Process values and alarm.
    output logic [31:0] O_POS,
    output logic [31:0] O_VEL,
    output logic O_RED_ZONE,
    output logic O_FAULT,
    output logic O_ALARM
);
    localparam int W = `EPS_DIV_W;
    localparam int TB = HW_ST_BITS + HW_MT_BITS;
    localparam logic [31:0] CPR = 32'h1 << HW_ST_BITS;
    localparam logic [31:0] TOT = 32'h1 << TB;

    eps_pkg::eps_top_st_t q;
    eps_pkg::eps_top_st_t d;

    // Divider handshake and operand mux.
    logic div_start;
    logic div_done;
    logic [W-1:0] div_num;
    logic [W-1:0] div_den;
    logic [W-1:0] div_quo;
    logic [W-1:0] div_rem;

    // Effective resolutions and scaled position.
    logic act;
    logic [31:0] steps_eff;
    logic [31:0] total_eff;
    logic [W-1:0] scaled;
    logic [W-1:0] mtot;

    // ======================================================================
    // Helpers.
    // ======================================================================
    // Magnitude of a signed count, used for velocity in both directions.
    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction : mag

    // Range check shared by the scaling settings.
    function automatic logic in_rng(input logic [31:0] v, lo, hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction : in_rng

    // ======================================================================
    // Effective settings; hardware values stand in while scaling is off.
    // ======================================================================
    assign act = q.cfg.ctrl[`EPS_CTRL_CLASS4] & q.cfg.ctrl[`EPS_CTRL_SCALE]; // [R1] [R17]
    assign steps_eff = act ? q.cfg.steps : CPR; // [R17]
    assign total_eff = act ? q.cfg.total : TOT; // [R17]
    // Product is shifted, not divided: cpr is always a power of two.
    assign scaled = (W'(I_RAW_POS) * W'(steps_eff)) >> HW_ST_BITS; // [R18]
    // Full physical travel in set steps, the base for the excess zone.
    assign mtot = W'(steps_eff) << HW_MT_BITS;

    // One divider is shared by every stage to keep area small.
    always_comb begin
        div_num = '0;
        div_den = W'(`EPS_STEPS_MIN);
        unique case (q.core.st)
            eps_pkg::EPS_S_REV: begin
                div_num = W'(total_eff); // [R4]
                div_den = W'(steps_eff);
            end
            eps_pkg::EPS_S_ZONE: begin
                // Remainder equals subtracting the set range until it fits.
                div_num = mtot; // [R6]
                div_den = W'(total_eff);
            end
            eps_pkg::EPS_S_POS: begin
                div_num = scaled; // [R18]
                div_den = W'(total_eff);
            end
            eps_pkg::EPS_S_VEL: begin
                unique case (q.cfg.vel_unit) // [R10]
                    `EPS_VU_SPS: div_num = W'(mag(q.core.delta)) * W'(`EPS_VEL_MUL_SPS);
                    `EPS_VU_S100MS: div_num = W'(mag(q.core.delta));
                    `EPS_VU_S10MS: begin
                        div_num = W'(mag(q.core.delta));
                        div_den = W'(`EPS_VEL_DIV_10MS);
                    end
                    `EPS_VU_RPM: begin
                        div_num = W'(mag(q.core.delta)) * W'(`EPS_VEL_MUL_RPM);
                        div_den = W'(steps_eff);
                    end
                endcase
            end
            default: begin
                div_num = '0;
            end
        endcase
    end

    assign div_start = (q.core.st != eps_pkg::EPS_S_IDLE) && !q.core.run;

    eps_div #(
        .W(W)
    ) u_div (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_start(div_start),
        .i_num(div_num),
        .i_den(div_den),
        .o_busy(),
        .o_done(div_done),
        .o_quo(div_quo),
        .o_rem(div_rem)
    );

    // ======================================================================
    // Next state of the bus slave, settings, sequencer and diagnostics.
    // ======================================================================
    always_comb begin
        logic addr_ph;
        logic [2:0] set;
        logic [2:0] clr;
        logic perr;
        logic [7:0] sol_lim;
        logic [31:0] rdata;
        addr_ph = I_HSEL & I_HTRANS[1] & I_HREADY;
        set = '0;
        clr = '0;
        perr = 1'b0;
        sol_lim = '0;
        rdata = '0;
        d = q;
        d.core.alarm = 1'b0;

        // Sequencer: each stage starts the divider, then takes its answer.
        if (q.core.st != eps_pkg::EPS_S_IDLE && !q.core.run) begin
            d.core.run = 1'b1;
        end
        unique case (q.core.st)
            eps_pkg::EPS_S_IDLE: begin
                d.core.st = eps_pkg::EPS_S_REV;
                d.core.dirty = 1'b0;
            end
            eps_pkg::EPS_S_REV: if (div_done) begin
                d.core.revs = div_quo[31:0]; // [R4]
                perr = (div_quo == '0);
                d.core.run = 1'b0;
                d.core.st = eps_pkg::EPS_S_ZONE;
            end
            eps_pkg::EPS_S_ZONE: if (div_done) begin
                d.core.zone = div_rem[31:0]; // [R6]
                d.core.run = 1'b0;
                d.core.st = eps_pkg::EPS_S_POS;
            end
            eps_pkg::EPS_S_POS: if (div_done) begin
                // The raw count wraps to zero, so the wrapped value jumps too.
                d.core.pos = div_rem[31:0]; // [R7] [R18]
                d.core.red = (scaled >= mtot - W'(q.core.zone)) && (q.core.zone != '0);
                d.core.run = 1'b0;
                if (q.core.dirty) begin
                    d.core.dirty = 1'b0;
                    d.core.st = eps_pkg::EPS_S_REV;
                end else if (q.core.vel_pend) begin
                    d.core.st = eps_pkg::EPS_S_VEL;
                end
            end
            eps_pkg::EPS_S_VEL: if (div_done) begin
                d.core.vel = q.core.delta[31] ? -32'(div_quo[31:0]) : 32'(div_quo[31:0]);
                d.core.vel_pend = 1'b0;
                d.core.run = 1'b0;
                d.core.st = eps_pkg::EPS_S_POS;
            end
            default: begin
                d.core.run = 1'b0;
                d.core.st = eps_pkg::EPS_S_IDLE;
            end
        endcase
        // The telegram without speed content shows no velocity.
        if (q.cfg.telegram == `EPS_TG_NO_VEL) begin
            d.core.vel = '0; // [R11]
        end

        // Fixed 100 ms time base, independent of the unit chosen.
        if (q.core.tick == 32'(VEL_TICKS - 1)) begin
            d.core.tick = '0; // [R12]
            d.core.vel_pend = 1'b1;
            d.core.delta = 32'(q.core.pos) - q.core.prev;
            d.core.prev = 32'(q.core.pos);
        end else begin
            d.core.tick = q.core.tick + 32'h1;
        end

        // Sign-of-life failure counting; the tolerance is honoured only
        // in compatibility mode, otherwise a single failure is allowed.
        sol_lim = q.cfg.ctrl[`EPS_CTRL_COMPAT_OFF] ? `EPS_SOL_NONCOMPAT : q.cfg.sol_max; // [R9]
        if (I_SOL_OK) begin
            d.core.sol_cnt = '0;
        end else if (I_SOL_FAIL && q.core.sol_cnt != `EPS_SOL_SAT) begin
            d.core.sol_cnt = q.core.sol_cnt + 8'h1;
        end

        // Register writes land in the data phase.
        if (q.bus.wr_pend) begin
            unique case (q.bus.addr)
                `EPS_OFF_CTRL: begin
                    d.cfg.ctrl = I_HWDATA[`EPS_CTRL_W-1:0]; // [R1] [R17]
                    d.core.dirty = 1'b1;
                end
                `EPS_OFF_STEPS: if (in_rng(I_HWDATA, `EPS_STEPS_MIN, CPR)) begin
                    d.cfg.steps = I_HWDATA; // [R2]
                    d.core.dirty = 1'b1;
                end else begin
                    perr = 1'b1;
                end
                `EPS_OFF_TOTAL: if (in_rng(I_HWDATA, `EPS_TOTAL_MIN, TOT)) begin
                    d.cfg.total = I_HWDATA; // [R3]
                    d.core.dirty = 1'b1;
                end else begin
                    perr = 1'b1;
                end
                `EPS_OFF_SOL_MAX: if (I_HWDATA[7:0] >= `EPS_SOL_MIN) begin
                    d.cfg.sol_max = I_HWDATA[7:0]; // [R9]
                end else begin
                    perr = 1'b1;
                end
                `EPS_OFF_VEL_UNIT: d.cfg.vel_unit = I_HWDATA[1:0]; // [R10]
                `EPS_OFF_TELEGRAM: d.cfg.telegram = I_HWDATA[7:0]; // [R11]
                `EPS_OFF_STATUS: clr = I_HWDATA[2:0];
                default: begin
                    // Unmapped or read-only: the write is dropped.
                    clr = '0;
                end
            endcase
        end

        // Faults are sticky; a new event beats a clear in the same cycle.
        set[`EPS_FLT_MEM] = I_MEM_FAULT; // [R13]
        set[`EPS_FLT_SOL] = q.core.sol_cnt > sol_lim; // [R9] [R13]
        set[`EPS_FLT_PARAM] = perr; // [R13]
        d.core.faults = (q.core.faults & ~clr) | set;
        d.core.fault = |d.core.faults;
        d.core.alarm = |(set & ~q.core.faults); // [R15]

        // Read mux; warning bits are fixed at zero.
        unique case (q.bus.addr)
            `EPS_OFF_CTRL: rdata = 32'(q.cfg.ctrl);
            `EPS_OFF_STEPS: rdata = q.cfg.steps;
            `EPS_OFF_TOTAL: rdata = q.cfg.total;
            `EPS_OFF_SOL_MAX: rdata = 32'(q.cfg.sol_max);
            `EPS_OFF_VEL_UNIT: rdata = 32'(q.cfg.vel_unit);
            `EPS_OFF_TELEGRAM: rdata = 32'(q.cfg.telegram);
            `EPS_OFF_STATUS: begin
                rdata = 32'(q.core.faults); // [R16] [R14]
                rdata[`EPS_ST_RED] = q.core.red;
                rdata[`EPS_ST_ACT] = act;
                rdata[`EPS_ST_BUSY] = q.core.dirty || q.core.st != eps_pkg::EPS_S_POS;
            end
            `EPS_OFF_SUPPORT: rdata = `EPS_FLT_SUPPORTED; // [R16] [R14]
            `EPS_OFF_REVS: rdata = q.core.revs;
            `EPS_OFF_ZONE: rdata = q.core.zone;
            `EPS_OFF_POS: rdata = q.core.pos;
            `EPS_OFF_VEL: rdata = q.core.vel;
            default: rdata = '0;
        endcase

        // Reads take one wait state so that a write just before is seen.
        if (q.bus.rd_pend) begin
            d.bus.hrdata = rdata; // [R15] [R16]
        end
        d.bus.wr_pend = addr_ph & I_HWRITE;
        d.bus.rd_pend = addr_ph & ~I_HWRITE;
        d.bus.hready = ~(addr_ph & ~I_HWRITE);
        if (addr_ph) begin
            d.bus.addr = I_HADDR[7:0];
        end
    end

    // ======================================================================
    // State register with reset defaults.
    // ======================================================================
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            q <= '0;
            q.bus.hready <= 1'b1;
            q.cfg.ctrl <= `EPS_RST_CTRL;
            q.cfg.steps <= CPR; // [R2]
            q.cfg.total <= TOT; // [R3]
            q.cfg.sol_max <= `EPS_RST_SOL_MAX; // [R9]
            q.cfg.vel_unit <= `EPS_RST_VEL_UNIT; // [R10]
            q.cfg.telegram <= `EPS_RST_TELEGRAM;
            q.core.st <= eps_pkg::EPS_S_IDLE;
        end else begin
            q <= d;
        end
    end

    assign O_HRDATA = q.bus.hrdata;
    assign O_HREADYOUT = q.bus.hready;
    assign O_HRESP = 1'b0;
    assign O_POS = q.core.pos;
    assign O_VEL = q.core.vel;
    assign O_RED_ZONE = q.core.red;
    assign O_FAULT = q.core.fault;
    assign O_ALARM = q.core.alarm;

    // ======================================================================
    // Checks.
    // ======================================================================
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);

    // Helper for the sign-of-life check.
    logic [7:0] sol_lim_chk;
    assign sol_lim_chk = q.cfg.ctrl[`EPS_CTRL_COMPAT_OFF] ? `EPS_SOL_NONCOMPAT : q.cfg.sol_max;

    sequence zone_taken_s;
        q.core.st == eps_pkg::EPS_S_ZONE && div_done;
    endsequence

    steps_range_a: assert property (in_rng(q.cfg.steps, `EPS_STEPS_MIN, CPR)) // [R2]
        else $error("steps per revolution out of range");
    total_range_a: assert property (in_rng(q.cfg.total, `EPS_TOTAL_MIN, TOT)) // [R3]
        else $error("total range out of range");
    revs_calc_a: assert property (q.core.st == eps_pkg::EPS_S_REV && div_done // [R4]
        |=> q.core.revs == $past(total_eff, W + 2) / $past(steps_eff, W + 2))
        else $error("revolution count wrong");
    zone_calc_a: assert property (zone_taken_s |=> q.core.zone < $past(total_eff, W + 2) // [R6]
        && 32'($past(mtot, W + 2) % W'($past(total_eff, W + 2))) == q.core.zone)
        else $error("excess zone wrong");
    native_pos_a: assert property (!$past(act, W + 1) && q.core.st == eps_pkg::EPS_S_POS // [R17]
        && div_done |=> O_POS == 32'($past(I_RAW_POS, W + 2)))
        else $error("native position not passed through");
    sol_fault_a: assert property (q.core.sol_cnt > sol_lim_chk |=> q.core.faults[1]) // [R9]
        else $error("sign of life fault not raised");
    vel_off_a: assert property (q.cfg.telegram == `EPS_TG_NO_VEL ##1 // [R11]
        q.cfg.telegram == `EPS_TG_NO_VEL |-> O_VEL == '0)
        else $error("velocity shown for telegram without velocity");
    vel_tick_a: assert property ($rose(q.core.vel_pend) // [R12]
        |-> $past(q.core.tick) == 32'(VEL_TICKS - 1))
        else $error("velocity update off the 100 ms grid");
    mem_fault_a: assert property (I_MEM_FAULT |=> O_FAULT && q.core.faults[0]) // [R13]
        else $error("memory fault not flagged");
    alarm_cause_a: assert property (O_ALARM |-> O_FAULT && $changed(q.core.faults)) // [R15]
        else $error("alarm without a new fault");
    read_wait_a: assert property (I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE
        |=> !O_HREADYOUT ##1 O_HREADYOUT)
        else $error("read wait state missing");

endmodule : eps_top
